// ---- csp_pkg.sv ----
package csp_pkg;

  // ************************************************************
  // register map and field layout
  // ************************************************************
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_DIV  = 2'h1;
  localparam logic [1:0] ADDR_DATA = 2'h2;
  localparam logic [1:0] ADDR_STAT = 2'h3;

  localparam int CTL_PRE  = 0;
  localparam int CTL_HIZ  = 2;
  localparam int CTL_PIN  = 3;
  localparam int CTL_POL  = 4;
  localparam int CTL_MSB  = 5;
  localparam int CTL_INT  = 6;
  localparam int CTL_IDLE = 7;

  localparam int STAT_BUSY = 0;
  localparam int STAT_HOLD = 1;

  // ************************************************************
  // reset values and counts
  // ************************************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam int         XFER_BITS = 8;
  localparam logic [4:0] PRE8_LAST  = 5'h07;
  localparam logic [4:0] PRE32_LAST = 5'h1f;

  typedef enum logic [1:0] {
    PRE_DIV1  = 2'b00,
    PRE_DIV8  = 2'b01,
    PRE_DIV32 = 2'b10,
    PRE_RSVD  = 2'b11
  } csp_pre_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_HOLD  = 2'b10
  } csp_state_t;

endpackage

// ---- csp_brg.sv ----
`timescale 1ns/1ps

module csp_brg #(
  parameter int DIV_W = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             clear,
  input  wire logic [1:0]       pre_sel,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  half_tick
);

  logic [4:0]       pre_cnt;
  logic [DIV_W-1:0] div_cnt;
  logic             src_tick;

  initial begin
    if (DIV_W < 1 || DIV_W > 16) begin
      $error("csp_brg: unsupported divisor width");
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pre_cnt <= 5'h00;
    end else begin
      pre_cnt <= pre_cnt + 5'h01;
    end
  end

  always_comb begin
    unique case (csp_pkg::csp_pre_t'(pre_sel))
      csp_pkg::PRE_DIV1:  src_tick = 1'b1;
      csp_pkg::PRE_DIV8:  src_tick = (pre_cnt[2:0] == csp_pkg::PRE8_LAST[2:0]);
      csp_pkg::PRE_DIV32: src_tick = (pre_cnt == csp_pkg::PRE32_LAST);
      default:            src_tick = 1'b0;
    endcase
  end

  // half period is n+1 source ticks
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt   <= '0;
      half_tick <= 1'b0;
    end else if (clear) begin
      div_cnt   <= '0;
      half_tick <= 1'b0;
    end else if (src_tick && div_cnt == divisor) begin
      div_cnt   <= '0;
      half_tick <= 1'b1;
    end else begin
      div_cnt   <= src_tick ? div_cnt + 1'b1 : div_cnt;
      half_tick <= 1'b0;
    end
  end

endmodule

// ---- csp_top.sv ----
`timescale 1ns/1ps

// How it works
// - each transfer shifts eight bits out while eight bits come in
// - internal clock rate is chosen prescaled source over 2(n+1)
// - clock source bit 0 takes transfer clock from the clock pin
// - a write to the shift data register is the only start
// - done event on last pulse's rising edge, falling if polarity 1
// - software picks LSB first or MSB first
// - software picks which clock edge outputs and samples data
// - external clock: idle serial output sits at software-chosen level
// - external clock: back-to-back bytes keep last bit between bytes
// - shifter follows every arriving pulse; peer stops after eight
// - internal transfer clock stops itself after eighth pulse
// - internal clock: last bit held half period, then high impedance
// - a write during that hold releases the output at once
// - stopped internal clock rests high for polarity 0, low for 1
// - serial output is port pin, data output or high impedance
// - clock pin is port pin, clock input or clock output
// - high impedance select floats the pins whatever their function
module csp_top #(
  parameter int DATA_W = csp_pkg::XFER_BITS
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe,
  input  wire logic        sin_i,
  output logic             sout_o,
  output logic             sout_oe,
  output logic             xfer_done_irq
);

  initial begin
    if (DATA_W != csp_pkg::XFER_BITS) begin
      $error("csp_top: only eight-bit transfers are supported");
    end
  end

  // ************************************************************
  // registers and decode
  // ************************************************************
  logic [7:0]              ctrl;
  logic [7:0]              divisor;
  logic [7:0]              sh;
  logic [2:0]              bit_cnt;
  logic                    drv;
  csp_pkg::csp_state_t     state;
  logic                    wr_ctrl;
  logic                    wr_div;
  logic                    wr_data;
  logic                    use_int;
  logic                    pol;
  logic                    half_tick;

  assign wr_ctrl = reg_wr && reg_addr == csp_pkg::ADDR_CTRL;
  assign wr_div  = reg_wr && reg_addr == csp_pkg::ADDR_DIV;
  assign wr_data = reg_wr && reg_addr == csp_pkg::ADDR_DATA;
  assign use_int = ctrl[csp_pkg::CTL_INT];
  assign pol     = ctrl[csp_pkg::CTL_POL];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl    <= csp_pkg::CTRL_RST;
      divisor <= csp_pkg::DIV_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata;
      end
      if (wr_div) begin
        divisor <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        csp_pkg::ADDR_CTRL: reg_rdata <= ctrl;
        csp_pkg::ADDR_DIV:  reg_rdata <= divisor;
        csp_pkg::ADDR_DATA: reg_rdata <= sh;
        csp_pkg::ADDR_STAT: begin
          reg_rdata                     <= 8'h00;
          reg_rdata[csp_pkg::STAT_BUSY] <= (state == csp_pkg::ST_SHIFT);
          reg_rdata[csp_pkg::STAT_HOLD] <= (state == csp_pkg::ST_HOLD);
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ************************************************************
  // pin synchronisers and edge detection
  // ************************************************************
  logic sclk_m;
  logic sclk_s;
  logic sclk_d;
  logic sin_m;
  logic sin_s;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_m <= 1'b1;
      sclk_s <= 1'b1;
      sclk_d <= 1'b1;
      sin_m  <= 1'b0;
      sin_s  <= 1'b0;
    end else begin
      sclk_m <= sclk_i;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      sin_m  <= sin_i;
      sin_s  <= sin_m;
    end
  end

  logic ext_rise;
  logic ext_fall;
  logic int_edge;
  logic lead;
  logic trail;
  logic done;

  assign ext_rise = sclk_s && !sclk_d;
  assign ext_fall = !sclk_s && sclk_d;
  assign int_edge = half_tick && state == csp_pkg::ST_SHIFT;

  // polarity 0 outputs on falling, samples on rising
  // external pin edges replace the generator
  always_comb begin
    if (use_int) begin
      lead  = int_edge && (sclk_o == !pol);
      trail = int_edge && (sclk_o == pol);
    end else begin
      lead  = pol ? ext_rise : ext_fall;
      trail = pol ? ext_fall : ext_rise;
    end
  end

  // done on the trailing edge of the eighth pulse
  assign done = trail && state == csp_pkg::ST_SHIFT && bit_cnt == 3'h7;

  csp_brg #(
    .DIV_W (8)
  ) u_brg (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .clear     (wr_data || state == csp_pkg::ST_IDLE),
    .pre_sel   (ctrl[csp_pkg::CTL_PRE +: 2]),
    .divisor   (divisor),
    .half_tick (half_tick)
  );

  // ************************************************************
  // transfer sequencing
  // ************************************************************
  // start on data write
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= csp_pkg::ST_IDLE;
    end else if (wr_data) begin
      state <= csp_pkg::ST_SHIFT;
    end else begin
      unique case (state)
        csp_pkg::ST_IDLE:  state <= csp_pkg::ST_IDLE;
        csp_pkg::ST_SHIFT: begin
          if (done) begin
            state <= use_int ? csp_pkg::ST_HOLD : csp_pkg::ST_IDLE;
          end
        end
        csp_pkg::ST_HOLD: begin
          if (half_tick || !use_int) begin
            state <= csp_pkg::ST_IDLE;
          end
        end
        default: state <= csp_pkg::ST_IDLE;
      endcase
    end
  end

  // generated clock toggles only while shifting
  // rest level is the inverse of polarity
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_o <= 1'b1;
    end else if (state != csp_pkg::ST_SHIFT || !use_int) begin
      sclk_o <= !pol;
    end else if (half_tick) begin
      sclk_o <= !sclk_o;
    end
  end

  // external pulses keep shifting past eight
  // received bits fill the same register
  // shift direction from bit order select
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sh      <= csp_pkg::DATA_RST;
      bit_cnt <= 3'h0;
    end else if (wr_data) begin
      sh      <= reg_wdata;
      bit_cnt <= 3'h0;
    end else if (trail && (state == csp_pkg::ST_SHIFT || !use_int)) begin
      sh      <= ctrl[csp_pkg::CTL_MSB] ? {sh[6:0], sin_s} : {sin_s, sh[7:1]};
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      xfer_done_irq <= 1'b0;
    end else begin
      xfer_done_irq <= done;
    end
  end

  // ************************************************************
  // pin drivers
  // ************************************************************
  // idle level loads only on a control write
  // otherwise the last bit stays between bytes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sout_o <= 1'b0;
    end else if (wr_ctrl && !reg_wdata[csp_pkg::CTL_INT] && state == csp_pkg::ST_IDLE) begin
      sout_o <= reg_wdata[csp_pkg::CTL_IDLE];
    end else if (lead && (state == csp_pkg::ST_SHIFT || !use_int)) begin
      sout_o <= ctrl[csp_pkg::CTL_MSB] ? sh[7] : sh[0];
    end
  end

  // first lead edge has put a bit out; avoids driving stale data
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      drv <= 1'b0;
    end else if (wr_data) begin
      drv <= 1'b0;
    end else if (lead) begin
      drv <= 1'b1;
    end
  end

  logic pins_on;
  assign pins_on = ctrl[csp_pkg::CTL_PIN] && !ctrl[csp_pkg::CTL_HIZ];

  // port pin, data output or high impedance
  // a write during hold floats at once
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sout_oe <= 1'b0;
    end else if (!pins_on) begin
      sout_oe <= 1'b0;
    end else if (!use_int) begin
      sout_oe <= 1'b1;
    end else begin
      sout_oe <= !wr_data && ((state == csp_pkg::ST_SHIFT && drv) || state == csp_pkg::ST_HOLD);
    end
  end

  // clock pin drives only for the internal clock
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_oe <= 1'b0;
    end else begin
      sclk_oe <= pins_on && use_int;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_start;
    wr_data && use_int;
  endsequence

  sequence s_done_pulse;
    xfer_done_irq ##1 !xfer_done_irq;
  endsequence

  property p_start;
    s_start |=> state == csp_pkg::ST_SHIFT && bit_cnt == 3'h0;
  endproperty
  a_start: assert property (p_start) else $error("no start on data write");

  property p_eight;
    (state == csp_pkg::ST_SHIFT && trail && bit_cnt != 3'h7 && !wr_data)
      |=> state == csp_pkg::ST_SHIFT && bit_cnt == $past(bit_cnt) + 3'h1;
  endproperty
  a_eight: assert property (p_eight) else $error("transfer left before eight bits");

  property p_irq;
    done |=> s_done_pulse;
  endproperty
  a_irq: assert property (p_irq) else $error("done pulse wrong");

  property p_rest;
    (state == csp_pkg::ST_IDLE && !wr_ctrl) |=> sclk_o == !pol;
  endproperty
  a_rest: assert property (p_rest) else $error("clock rest level wrong");

  property p_stop;
    (state == csp_pkg::ST_IDLE && !wr_data && !wr_ctrl) ##1 !wr_ctrl |=> $stable(sclk_o);
  endproperty
  a_stop: assert property (p_stop) else $error("clock moved while idle");

  property p_hold;
    (state == csp_pkg::ST_HOLD && wr_data) |=> !sout_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not cut by write");

  property p_hiz;
    ctrl[csp_pkg::CTL_HIZ] |=> !sout_oe && !sclk_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin driven under hiz select");

  property p_idle;
    (wr_ctrl && !reg_wdata[csp_pkg::CTL_INT] && state == csp_pkg::ST_IDLE)
      |=> sout_o == $past(reg_wdata[csp_pkg::CTL_IDLE]);
  endproperty
  a_idle: assert property (p_idle) else $error("idle level not applied");

  property p_order;
    (trail && state == csp_pkg::ST_SHIFT && !wr_data && !ctrl[csp_pkg::CTL_MSB])
      |=> sh[7] == $past(sin_s);
  endproperty
  a_order: assert property (p_order) else $error("lsb first shift wrong");

endmodule

// ---- csp_peer.sv ----
`timescale 1ns/1ps

module csp_peer (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       pol,
  input  wire logic       sclk,
  input  wire logic       sout,
  input  wire logic [7:0] tx_byte,
  input  wire logic       arm,
  input  wire logic       go,
  input  wire logic [7:0] half,
  output logic            sin,
  output logic            pclk,
  output logic      [7:0] seen,
  output logic      [9:0] period
);
  // ************************************************************
  // far-side serial peer
  // ************************************************************
  logic       sclk_q;
  logic [3:0] k;
  logic [4:0] tcnt;
  logic [7:0] hcnt;
  logic [9:0] cnt;
  logic       lead;
  logic       trail;

  // rest level is the inverse of polarity
  assign lead  = (sclk_q == ~pol) && (sclk == pol);
  assign trail = (sclk_q == pol) && (sclk == ~pol);

  // data on lead, sample on trail
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b1;
      k      <= 4'h0;
      sin    <= 1'b0;
      seen   <= 8'h00;
      cnt    <= 10'h000;
      period <= 10'h000;
    end else begin
      sclk_q <= sclk;
      cnt    <= cnt + 10'h001;
      if (arm) begin
        k   <= 4'h0;
        sin <= tx_byte[7];
      end else if (lead) begin
        // extra pulses see a changing line, not a stale bit
        sin <= k[3] ? ~sin : tx_byte[3'h7 - k[2:0]];
      end else if (trail) begin
        seen   <= {seen[6:0], sout};
        k      <= k + 4'h1;
        period <= cnt + 10'h001;
        cnt    <= 10'h000;
      end
    end
  end

  // eight pulses only, resting between frames
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pclk <= 1'b1;
      tcnt <= 5'h00;
      hcnt <= 8'h00;
    end else if (go) begin
      tcnt <= 5'h10;
      hcnt <= 8'h00;
    end else if (tcnt == 5'h00) begin
      pclk <= ~pol;
    end else if (hcnt == half - 8'h01) begin
      pclk <= ~pclk;
      tcnt <= tcnt - 5'h01;
      hcnt <= 8'h00;
    end else begin
      hcnt <= hcnt + 8'h01;
    end
  end
endmodule

// ---- clock_sync_serial_port_tb.sv ----
`timescale 1ns/1ps

module clock_sync_serial_port_tb;
  logic        core_clk;
  logic        rstn;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        sclk_o, sclk_oe, sout_o, sout_oe, xfer_done_irq;
  logic        sclk_w, sout_w, sin, pclk, pol, arm, go, tog;
  logic [7:0]  peer_tx, half, seen, st;
  logic [9:0]  period;
  logic [31:0] seed;
  int          err_total;
  int          n_checks;

  // undriven data line changes every cycle; undriven clock line comes from the peer
  assign sclk_w = sclk_oe ? sclk_o : pclk;
  assign sout_w = sout_oe ? sout_o : tog;

  csp_top dut_u (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .sin_i(sin), .sout_o(sout_o),
    .sout_oe(sout_oe), .xfer_done_irq(xfer_done_irq));

  csp_peer peer_u (.core_clk(core_clk), .rstn(rstn), .pol(pol), .sclk(sclk_w),
    .sout(sout_w), .tx_byte(peer_tx), .arm(arm), .go(go), .half(half), .sin(sin),
    .pclk(pclk), .seen(seen), .period(period));

  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) tog <= ~tog;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] rnd8();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  function automatic logic [7:0] rev8(logic [7:0] v);
    return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
  endfunction

  task automatic chk1(string nm, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chkn(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic start_peer(logic [7:0] b);
    @(posedge core_clk);
    peer_tx <= b;
    arm     <= 1'b1;
    @(posedge core_clk);
    arm <= 1'b0;
  endtask

  task automatic wait_irq();
    int w;
    w = 0;
    while (xfer_done_irq !== 1'b1 && w < 3000) begin
      @(posedge core_clk);
      #1;
      w++;
    end
    chk1("irq_seen", 1'b1, xfer_done_irq);
  endtask

  task automatic xfer_int(logic [1:0] pre, logic p, logic m);
    logic [7:0] n, d, pt;
    int         hp, h;
    // half period of at least four cycles covers the peer's sin sync delay
    n = (pre == 2'b00) ? 8'h03 + (rnd8() & 8'h03) : rnd8() & 8'h01;
    d = rnd8();
    pt = rnd8();
    hp = (n + 1) * ((pre == 2'b00) ? 1 : (pre == 2'b01) ? 8 : 32);
    @(posedge core_clk);
    pol <= p;
    wr(csp_pkg::ADDR_CTRL, {1'b0, 1'b1, m, p, 1'b1, 1'b0, pre});
    wr(csp_pkg::ADDR_DIV, n);
    start_peer(pt);
    wr(csp_pkg::ADDR_DATA, d);
    repeat (4) @(posedge core_clk);
    rd(csp_pkg::ADDR_STAT, st);
    chk1("busy", 1'b1, st[csp_pkg::STAT_BUSY]);
    wait_irq();
    chk1("sclk_done", ~p, sclk_w);
    chk1("sclk_oe", 1'b1, sclk_oe);
    h = 0;
    while (sout_oe === 1'b1 && h < 2000) begin
      @(posedge core_clk);
      #1;
      h++;
    end
    chk1("hold_len", 1'b1, h >= hp - 2 && h <= hp + 1);
    chk1("sclk_rest", ~p, sclk_w);
    chkn("period", 2 * hp, period);
    chk8("peer_seen", m ? d : rev8(d), seen);
    rd(csp_pkg::ADDR_DATA, st);
    chk8("rx", m ? pt : rev8(pt), st);
  endtask

  task automatic ext_pair(logic p);
    logic [7:0] d, pt;
    @(posedge core_clk);
    pol <= p;
    wr(csp_pkg::ADDR_CTRL, {1'b1, 1'b0, p, p, 4'h8});
    @(posedge core_clk);
    #1;
    chk1("idle_hi", 1'b1, sout_w);
    wr(csp_pkg::ADDR_CTRL, {1'b0, 1'b0, p, p, 4'h8});
    repeat (20) @(posedge core_clk);
    #1;
    chk1("idle_lo", 1'b0, sout_w);
    chk1("sclk_in", 1'b0, sclk_oe);
    rd(csp_pkg::ADDR_STAT, st);
    chk1("no_start", 1'b0, st[csp_pkg::STAT_BUSY]);
    for (int b = 0; b < 2; b++) begin
      d = rnd8() | (p ? 8'h01 : 8'h80);
      pt = rnd8();
      start_peer(pt);
      wr(csp_pkg::ADDR_DATA, d);
      @(posedge core_clk);
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      wait_irq();
      repeat (4) @(posedge core_clk);
      #1;
      chk8("ext_seen", p ? d : rev8(d), seen);
      chk1("last_bit_kept", 1'b1, sout_w);
      rd(csp_pkg::ADDR_DATA, st);
      chk8("ext_rx", p ? pt : rev8(pt), st);
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [7:0] rv [4];
    rv = '{csp_pkg::CTRL_RST, csp_pkg::DIV_RST, csp_pkg::DATA_RST, 8'h00};
    core_clk = 1'b0;
    rstn = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {pol, arm, go, tog, peer_tx} = '0;
    half = 8'h06;
    seed = 32'h0001_12ae;
    err_total = 0;
    n_checks = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk1("sclk_reset", 1'b1, sclk_o);
    chk1("sout_oe_reset", 1'b0, sout_oe);
    wr(csp_pkg::ADDR_STAT, 8'hff);
    for (int a = 0; a < 4; a++) begin
      rd(2'(a), st);
      chk8("reset_reg", rv[a], st);
    end
    for (int i = 0; i < 12; i++)
      xfer_int(2'(i % 3), 1'((i / 3) % 2), 1'(i / 6));
    pol <= 1'b0;
    wr(csp_pkg::ADDR_CTRL, 8'h69);
    wr(csp_pkg::ADDR_DIV, 8'h00);
    start_peer(8'h3c);
    wr(csp_pkg::ADDR_DATA, 8'ha5);
    wait_irq();
    start_peer(8'hc3);
    wr(csp_pkg::ADDR_DATA, 8'h5a);
    #1;
    chk1("hold_cut", 1'b0, sout_oe);
    wait_irq();
    // let the half-period hold run out before the mode change
    repeat (20) @(posedge core_clk);
    chk8("second_seen", 8'h5a, seen);
    ext_pair(1'b0);
    ext_pair(1'b1);
    // reserved source: generator never ticks, transfer stays pending
    wr(csp_pkg::ADDR_CTRL, 8'h4b);
    wr(csp_pkg::ADDR_DATA, 8'h96);
    repeat (40) @(posedge core_clk);
    rd(csp_pkg::ADDR_STAT, st);
    chk1("rsvd_busy", 1'b1, st[csp_pkg::STAT_BUSY]);
    chk1("rsvd_sclk", 1'b1, sclk_w);
    wr(csp_pkg::ADDR_CTRL, 8'h4c);
    @(posedge core_clk);
    #1;
    chk1("hiz_sout", 1'b0, sout_oe);
    chk1("hiz_sclk", 1'b0, sclk_oe);
    wr(csp_pkg::ADDR_CTRL, 8'h40);
    @(posedge core_clk);
    #1;
    chk1("port_sout", 1'b0, sout_oe);
    chk1("port_sclk", 1'b0, sclk_oe);
    summarize();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    summarize();
  end
endmodule
